// ===== rpcs_defines.vh
// Purpose: Offsets, field positions, resets and codes for the radio settings bank
// Assumes: Byte addresses on a 32-bit word bus
// Notes: Definitions only
`ifndef RPCS_DEFINES_VH
`define RPCS_DEFINES_VH
`define RPCS_AW 12
`define RPCS_OFF_RX_ADDRESS_ENABLE 12'h530
`define RPCS_OFF_CHECKSUM_CONFIG 12'h534
`define RPCS_OFF_CHECKSUM_POLYNOMIAL 12'h538
`define RPCS_OFF_CHECKSUM_SEED 12'h53c
`define RPCS_OFF_INTERFRAME_SPACING 12'h544
`define RPCS_OFF_SIGNAL_STRENGTH_SAMPLE 12'h548
`define RPCS_OFF_RADIO_STATE 12'h550
`define RPCS_OFF_WHITENING_SEED 12'h554
`define RPCS_OFF_BIT_COUNTER_COMPARE 12'h560
`define RPCS_OFF_TX_LOGICAL_SELECT 12'h52c
`define RPCS_OFF_PACKET_CONTROL 12'h570
`define RPCS_RST_ZERO 32'h00000000
`define RPCS_RST_WHITENING_SEED 7'h40
`define RPCS_WHITE_FIXED_BIT 6
`define RPCS_CKLEN_LSB 0
`define RPCS_CKCOV_LSB 8
`define RPCS_COV_INCLUDE 2'h0
`define RPCS_COV_SKIP 2'h1
`define RPCS_COV_IEEE 2'h2
`define RPCS_ST_DISABLED 4'h0
`define RPCS_ST_RX_RAMPUP 4'h1
`define RPCS_ST_RX_IDLE 4'h2
`define RPCS_ST_RX 4'h3
`define RPCS_ST_RX_DISABLING 4'h4
`define RPCS_ST_TX_RAMPUP 4'h9
`define RPCS_ST_TX_IDLE 4'ha
`define RPCS_ST_TX 4'hb
`define RPCS_ST_TX_DISABLING 4'hc
`endif

// ===== rpcs_state_code.v
// Purpose: Maps radio state indication to the reported state code
// Assumes: Binary-coded phase and a TX side select from the radio sequencer
// Notes: Unknown combinations report disabled
`include "rpcs_defines.vh"
module rpcs_state_code (
    // Sequencer state
    input wire tx_side,
    input wire [2:0] phase,
    // Code
    output reg [3:0] code
);
    always @* begin
        code = `RPCS_ST_DISABLED;
        case (phase)
            3'h1: code = tx_side ? `RPCS_ST_TX_RAMPUP : `RPCS_ST_RX_RAMPUP;
            3'h2: code = tx_side ? `RPCS_ST_TX_IDLE : `RPCS_ST_RX_IDLE;
            3'h3: code = tx_side ? `RPCS_ST_TX : `RPCS_ST_RX;
            3'h4: code = tx_side ? `RPCS_ST_TX_DISABLING : `RPCS_ST_RX_DISABLING;
            default: code = `RPCS_ST_DISABLED;
        endcase
    end
endmodule

// ===== rpcs_white_seed.v
// Purpose: Reverses the whitening seed into shift register load order
// Assumes: Seven-bit seed
// Notes: Position 6 is always one
`include "rpcs_defines.vh"
module rpcs_white_seed (
    // Stored seed
    input wire [6:0] seed,
    // Shift register load
    output wire [6:0] lfsr_load
);
    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_rev
            assign lfsr_load[6 - i] = seed[i];
        end
    endgenerate
endmodule

// ===== rpcs_regs.v
// Purpose: Register bank for packet radio checksum, whitening and state
// Assumes: Single clock, synchronous active-low reset, simple strobe bus
// Notes: Read data valid one cycle after the read strobe only
`include "rpcs_defines.vh"
module rpcs_regs #(
    parameter AW = `RPCS_AW
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Register bus
    input wire [AW-1:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rdata,
    // Radio core status
    input wire tx_side,
    input wire [2:0] phase,
    input wire [6:0] rssi_magnitude,
    input wire rssi_valid,
    // Radio core settings
    output wire [7:0] rx_address_enable,
    output wire [2:0] tx_logical_select,
    output wire checksum_enable,
    output wire [1:0] checksum_length,
    output wire [1:0] checksum_coverage,
    output wire skip_address,
    output wire skip_length,
    output wire [23:0] checksum_polynomial,
    output wire [23:0] checksum_seed,
    output wire [8:0] interframe_spacing,
    output wire whitening_enable,
    output wire [6:0] whitening_load,
    output wire [31:0] bit_counter_compare
);
    reg [7:0] rxen_q;
    reg [2:0] txsel_q;
    reg [1:0] cklen_q;
    reg [1:0] ckcov_q;
    reg [23:0] poly_q;
    reg [23:0] seed_q;
    reg [8:0] interframe_spacing_q;
    reg [6:0] rssi_q;
    reg [6:0] white_q;
    reg white_en_q;
    reg [31:0] bcc_q;
    reg [31:0] rdata_d;
    wire [3:0] state_code;

    rpcs_state_code u_state (
        .tx_side(tx_side),
        .phase(phase),
        .code(state_code)
    );

    rpcs_white_seed u_white (
        .seed(white_q),
        .lfsr_load(whitening_load)
    );

    // Register writes
    always @(posedge mclk) begin
        if (!rst_b) begin
            rxen_q <= 8'h00;
            txsel_q <= 3'h0;
            cklen_q <= 2'h0;
            ckcov_q <= 2'h0;
            poly_q <= 24'h000000;
            seed_q <= 24'h000000;
            interframe_spacing_q <= 9'h000;
            white_q <= `RPCS_RST_WHITENING_SEED;
            white_en_q <= 1'b0;
            bcc_q <= 32'h00000000;
        end else if (wr_en) begin
            if (addr == `RPCS_OFF_RX_ADDRESS_ENABLE) begin
                rxen_q <= wdata[7:0];
            end else if (addr == `RPCS_OFF_TX_LOGICAL_SELECT) begin
                txsel_q <= wdata[2:0];
            end else if (addr == `RPCS_OFF_CHECKSUM_CONFIG) begin
                cklen_q <= wdata[`RPCS_CKLEN_LSB+1:`RPCS_CKLEN_LSB];
                ckcov_q <= wdata[`RPCS_CKCOV_LSB+1:`RPCS_CKCOV_LSB];
            end else if (addr == `RPCS_OFF_CHECKSUM_POLYNOMIAL) begin
                poly_q <= wdata[23:0];
            end else if (addr == `RPCS_OFF_CHECKSUM_SEED) begin
                seed_q <= wdata[23:0];
            end else if (addr == `RPCS_OFF_INTERFRAME_SPACING) begin
                interframe_spacing_q <= wdata[8:0];
            end else if (addr == `RPCS_OFF_WHITENING_SEED) begin
                white_q <= wdata[6:0] | `RPCS_RST_WHITENING_SEED;
            end else if (addr == `RPCS_OFF_BIT_COUNTER_COMPARE) begin
                bcc_q <= wdata;
            end else if (addr == `RPCS_OFF_PACKET_CONTROL) begin
                white_en_q <= wdata[0];
            end
        end
    end

    // Signal strength capture from the radio core
    always @(posedge mclk) begin
        if (!rst_b) begin
            rssi_q <= 7'h00;
        end else if (rssi_valid) begin
            rssi_q <= rssi_magnitude;
        end
    end

    // Read mux; unmapped reads return zero
    always @* begin
        rdata_d = 32'h00000000;
        if (addr == `RPCS_OFF_RX_ADDRESS_ENABLE) begin
            rdata_d = {24'h000000, rxen_q};
        end else if (addr == `RPCS_OFF_TX_LOGICAL_SELECT) begin
            rdata_d = {29'h00000000, txsel_q};
        end else if (addr == `RPCS_OFF_CHECKSUM_CONFIG) begin
            rdata_d = {22'h000000, ckcov_q, 6'h00, cklen_q};
        end else if (addr == `RPCS_OFF_CHECKSUM_POLYNOMIAL) begin
            rdata_d = {8'h00, poly_q};
        end else if (addr == `RPCS_OFF_CHECKSUM_SEED) begin
            rdata_d = {8'h00, seed_q};
        end else if (addr == `RPCS_OFF_INTERFRAME_SPACING) begin
            rdata_d = {23'h000000, interframe_spacing_q};
        end else if (addr == `RPCS_OFF_SIGNAL_STRENGTH_SAMPLE) begin
            rdata_d = {25'h0000000, rssi_q};
        end else if (addr == `RPCS_OFF_RADIO_STATE) begin
            rdata_d = {28'h0000000, state_code};
        end else if (addr == `RPCS_OFF_WHITENING_SEED) begin
            rdata_d = {25'h0000000, white_q};
        end else if (addr == `RPCS_OFF_BIT_COUNTER_COMPARE) begin
            rdata_d = bcc_q;
        end else if (addr == `RPCS_OFF_PACKET_CONTROL) begin
            rdata_d = {31'h00000000, white_en_q};
        end
    end

    // Read data held only in the cycle after the strobe
    always @(posedge mclk) begin
        if (!rst_b) begin
            rdata <= 32'h00000000;
        end else if (rd_en) begin
            rdata <= rdata_d;
        end else begin
            rdata <= 32'h00000000;
        end
    end

    assign rx_address_enable = rxen_q;
    assign tx_logical_select = txsel_q;
    assign checksum_length = cklen_q;
    assign checksum_enable = (cklen_q != 2'h0);
    assign checksum_coverage = ckcov_q;
    assign skip_address = (ckcov_q == `RPCS_COV_SKIP) || (ckcov_q == `RPCS_COV_IEEE);
    assign skip_length = (ckcov_q == `RPCS_COV_IEEE);
    assign checksum_polynomial = poly_q;
    assign checksum_seed = seed_q;
    assign interframe_spacing = interframe_spacing_q;
    assign whitening_enable = white_en_q;
    assign bit_counter_compare = bcc_q;
endmodule

// ===== rpcs_regs_chk.sv
// Purpose: Port assertions for the radio settings register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into every register bank instance
`include "rpcs_defines.vh"
module rpcs_regs_chk #(
    parameter AW = 12
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Register bus
    input wire [AW-1:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] rdata,
    // Status and settings
    input wire tx_side,
    input wire [2:0] phase,
    input wire checksum_enable,
    input wire [1:0] checksum_length,
    input wire [1:0] checksum_coverage,
    input wire skip_address,
    input wire skip_length,
    input wire [23:0] checksum_seed,
    input wire [6:0] whitening_load
);
    wire [23:0] wr_seed = wdata[23:0];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    function automatic logic [3:0] st_code(input logic t, input logic [2:0] p);
        st_code = (p == 3'h0 || p > 3'h4) ? 4'h0 : {t, p};
    endfunction
    sequence s_state_rd;
        rd_en && addr == `RPCS_OFF_RADIO_STATE;
    endsequence
    sequence s_seed_wr;
        wr_en && addr == `RPCS_OFF_CHECKSUM_SEED;
    endsequence
    chk_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data not zero outside read slot");
    chk_len_enable: assert property (checksum_enable == (checksum_length != 2'h0))
        else $error("checksum enable does not follow length");
    chk_cov_include: assert property (checksum_coverage == 2'h0 |-> !skip_address && !skip_length)
        else $error("coverage 0 skips a field");
    chk_cov_skip: assert property (checksum_coverage == 2'h1 |-> skip_address && !skip_length)
        else $error("coverage 1 wrong skip flags");
    chk_cov_ieee: assert property (checksum_coverage == 2'h2 |-> skip_address && skip_length)
        else $error("coverage 2 wrong skip flags");
    chk_white_fixed: assert property (whitening_load[0] && $stable(whitening_load[0]))
        else $error("whitening fixed bit not one");
    chk_state_code: assert property (s_state_rd |=> rdata == {28'h0, st_code($past(tx_side), $past(phase))})
        else $error("state code read wrong");
    chk_seed_load: assert property (s_seed_wr |=> checksum_seed == $past(wr_seed))
        else $error("checksum seed not loaded");
endmodule
bind rpcs_regs rpcs_regs_chk #(.AW(AW)) rpcs_regs_chk_inst (.mclk, .rst_b, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .tx_side, .phase, .checksum_enable, .checksum_length,
    .checksum_coverage, .skip_address, .skip_length, .checksum_seed, .whitening_load);

// ===== rpcs_regs_bench.sv
// Purpose: Self-checking bench for the radio settings register bank
// Assumes: Strobe bus, read data in the cycle after the read strobe
// Notes: No random stimulus
module rpcs_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_b = 0, wr_en = 0, rd_en = 0, tx_side = 0, rssi_valid = 0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] phase = 3'h0;
    logic [6:0] rssi_magnitude = 7'h0;
    logic [31:0] rdata, bit_counter_compare;
    logic [23:0] checksum_polynomial, checksum_seed;
    logic [8:0] interframe_spacing;
    logic [7:0] rx_address_enable;
    logic [6:0] whitening_load;
    logic [2:0] tx_logical_select;
    logic [1:0] checksum_length, checksum_coverage;
    logic checksum_enable, skip_address, skip_length, whitening_enable;
    logic [11:0] offs [7] = '{12'h530, 12'h534, 12'h53c, 12'h544, 12'h548, 12'h550, 12'h554};
    int n_errors = 0, check_count = 0;
    rpcs_regs rpcs_regs_inst (.mclk, .rst_b, .addr, .wdata, .wr_en, .rd_en, .rdata, .tx_side,
        .phase, .rssi_magnitude, .rssi_valid, .rx_address_enable, .tx_logical_select,
        .checksum_enable, .checksum_length, .checksum_coverage, .skip_address, .skip_length,
        .checksum_polynomial, .checksum_seed, .interframe_spacing, .whitening_enable,
        .whitening_load, .bit_counter_compare);
    task automatic check(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 check($sformatf("read %h", a), exp, rdata);
    endtask
    task automatic end_of_test;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        forever #4 mclk = ~mclk;
    end
    initial begin
        #50000;
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (offs[k]) rd(offs[k], offs[k] == 12'h554 ? 32'h40 : 32'h0);
        $display("Test reset values done");
        for (int v = 0; v < 12; v++) begin
            wr(12'h534, {22'h0, v[3:2], 6'h0, v[1:0]});
            check("enable", v[1:0] != 0, checksum_enable);
            check("skip addr", v[3:2] != 0, skip_address);
            check("skip len", v[3:2] == 2, skip_length);
            check("length", v[1:0], checksum_length);
            check("coverage", v[3:2], checksum_coverage);
            rd(12'h534, {22'h0, v[3:2], 6'h0, v[1:0]});
        end
        wr(12'h534, 32'h3);
        check("long range length", 32'h3, checksum_length);
        $display("Test checksum config done");
        wr(12'h530, 32'hffffffa5);
        check("rx enable", 32'ha5, rx_address_enable);
        rd(12'h530, 32'ha5);
        wr(12'h53c, 32'hffabcdef);
        rd(12'h53c, 32'habcdef);
        check("seed", 32'habcdef, checksum_seed);
        wr(12'h560, 32'hdeadbeef);
        check("bit compare", 32'hdeadbeef, bit_counter_compare);
        rd(12'h560, 32'hdeadbeef);
        wr(12'h5fc, 32'hffffffff);
        check("unmapped write", 32'hdeadbeef, bit_counter_compare);
        wr(12'h538, 32'h00123456);
        check("poly", 32'h123456, checksum_polynomial);
        wr(12'h544, 32'h0000ffff);
        check("spacing", 32'h1ff, interframe_spacing);
        wr(12'h52c, 32'h5);
        check("tx select", 32'h5, tx_logical_select);
        wr(12'h570, 32'h1);
        check("white en", 32'h1, whitening_enable);
        wr(12'h554, 32'h3);
        check("white load", 32'h61, whitening_load);
        rd(12'h554, 32'h43);
        $display("Test settings done");
        @(posedge mclk);
        rssi_magnitude <= 7'h5a;
        rssi_valid <= 1'b1;
        @(posedge mclk);
        rssi_valid <= 1'b0;
        wr(12'h548, 32'h7f);
        rd(12'h548, 32'h5a);
        rd(12'h5fc, 32'h0);
        for (int s = 0; s < 16; s++) begin
            @(posedge mclk);
            tx_side <= s[3];
            phase <= s[2:0];
            rd(12'h550, (s[2:0] == 0 || s[2:0] > 4) ? 32'h0 : s[3:0]);
        end
        $display("Test status done");
        end_of_test;
    end
endmodule
